// file: rtl/csco_pkg.sv
// Package: register map, field positions and constants of the channel status and clock-out block
package csco_pkg;

  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 5'h10;

  // Control register fields
  localparam int          CTL_LOS_EN      = 0;
  localparam int          CTL_OBS_SEL_LO  = 1;
  localparam int          CTL_OBS_SEL_W   = 2;
  localparam int          CTL_REG_PD      = 3;
  localparam int          CTL_GPS_MODE    = 4;
  localparam int          CTL_REFSEL_A    = 5;
  localparam int          CTL_REFSEL_B    = 6;
  localparam int          CTL_CLKSRC_A    = 7;
  localparam int          CTL_CLKSRC_B    = 8;
  localparam int          CTL_CLKEN_A     = 9;
  localparam int          CTL_CLKEN_B     = 10;
  localparam int          CTL_W           = 11;
  localparam logic [CTL_W-1:0] CTL_RESET  = 11'h601;

  // Status and event fields
  localparam int          ST_LOS          = 0;
  localparam int          ST_PARTNER_OK   = 1;
  localparam int          ST_TX_OK        = 2;
  localparam int          ST_PD_B         = 3;
  localparam int          ST_W            = 4;
  localparam int          EV_W            = 4;
  localparam int          EV_LOS_SET      = 0;
  localparam int          EV_LOS_CLR      = 1;
  localparam int          EV_PARTNER_CHG  = 2;
  localparam int          EV_PD_EXIT      = 3;

  // Observation selector codes on the loss-of-signal pin
  localparam logic [1:0]  OBS_LOS         = 2'h0;
  localparam logic [1:0]  OBS_PARTNER_OK  = 2'h1;
  localparam logic [1:0]  OBS_TX_OK       = 2'h2;
  localparam logic [1:0]  OBS_PD          = 2'h3;

  // Output clock divider selections
  localparam int          DIV_BYTE_16     = 16;
  localparam int          DIV_BYTE_20     = 20;
  localparam int          DIV_VCO_FULL    = 8;
  localparam int          DIV_VCO_SUB     = 4;

endpackage : csco_pkg

// file: rtl/csco_lane_sync.sv
`timescale 1ns/1ps
// Two-flop level synchroniser for one lane status bit
module csco_lane_sync
  import csco_pkg::*;
(
  input  wire logic clk,     // Block clock
  input  wire logic rst_n,   // Synchronised reset, active low
  input  wire logic din,     // Asynchronous level
  output logic      dout     // Synchronised level
);

  logic s1_r;
  logic s2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  assign dout = s2_r;

endmodule : csco_lane_sync

// file: rtl/csco_top.sv
`timescale 1ns/1ps
// Channel B status pins, power down, reference select and output clock control
module csco_top
  import csco_pkg::*;
(
  input  wire logic              ref_clk,                         // 20 MHz block clock
  input  wire logic              arst_n,                          // Device reset, active low
  input  wire logic              wb_cyc_i,                        // Wishbone cycle
  input  wire logic              wb_stb_i,                        // Wishbone strobe
  input  wire logic              wb_we_i,                         // Wishbone write enable
  input  wire logic [ADDR_W-1:0] wb_adr_i,                        // Wishbone byte address
  input  wire logic [3:0]        wb_sel_i,                        // Wishbone byte selects
  input  wire logic [DATA_W-1:0] wb_dat_i,                        // Wishbone write data
  output logic      [DATA_W-1:0] wb_dat_o,                        // Wishbone read data
  output logic                   wb_ack_o,                        // Wishbone acknowledge
  input  wire logic              rx_below_low_thresh_b,           // Swing at or below low threshold
  input  wire logic              rx_above_high_thresh_b,          // Swing above high threshold
  input  wire logic              partner_rx_lanes_aligned_in_b,   // Partner receive alignment level
  input  wire logic              tx_lanes_aligned_b,              // Internal transmit alignment
  input  wire logic              channel_b_power_down_n,          // Channel B power down, active low
  input  wire logic              channel_a_power_down_n,          // Channel A power down, active low
  input  wire logic              reference_clock_zero,            // Reference clock zero
  input  wire logic              reference_clock_one,             // Reference clock one
  input  wire logic              byte_clk_a,                      // Channel A recovered byte clock
  input  wire logic              byte_clk_b,                      // Channel B recovered byte clock
  input  wire logic              vco_half_clk_a,                  // Channel A VCO clock halved
  input  wire logic              vco_half_clk_b,                  // Channel B VCO clock halved
  output logic                   ref_clk_sel_a,                   // Channel A reference choice
  output logic                   ref_clk_sel_b,                   // Channel B reference choice
  output logic                   channel_a_ref_clk,               // Channel A chosen reference
  output logic                   channel_b_ref_clk,               // Channel B chosen reference
  output logic                   channel_a_output_clock,          // Channel A output clock
  output logic                   channel_a_output_clock_oe,       // Channel A output clock enable
  output logic                   channel_b_output_clock,          // Channel B output clock
  output logic                   channel_b_output_clock_oe,       // Channel B output clock enable
  output logic                   rx_signal_loss_flag_b,           // Loss-of-signal pin level
  output logic                   rx_signal_loss_flag_b_oe,        // Loss-of-signal pin enable
  output logic                   tx_lanes_aligned_out_b,          // Transmit alignment to partner
  output logic                   channel_b_powered_down,          // Channel B power-down state
  output logic                   irq                              // Interrupt, active high level
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic partner_ok_s;
  logic pd_b_s;
  logic pd_a_s;
  // Power-down pins inverted before syncing: reset reads as powered up

  csco_lane_sync u_sync_partner (
    .clk   (ref_clk),
    .rst_n (rst_n_r),
    .din   (partner_rx_lanes_aligned_in_b),
    .dout  (partner_ok_s)
  );

  csco_lane_sync u_sync_pdb (
    .clk   (ref_clk),
    .rst_n (rst_n_r),
    .din   (!channel_b_power_down_n),
    .dout  (pd_b_s)
  );

  csco_lane_sync u_sync_pda (
    .clk   (ref_clk),
    .rst_n (rst_n_r),
    .din   (!channel_a_power_down_n),
    .dout  (pd_a_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [CTL_W-1:0]  ctrl_r,      ctrl_nxt;
  logic [EV_W-1:0]   irq_stat_r,  irq_stat_nxt;
  logic [EV_W-1:0]   irq_en_r,    irq_en_nxt;
  logic              los_r,       los_nxt;
  logic              partner_q_r, partner_q_nxt;
  logic              pd_q_r,      pd_q_nxt;
  logic              ack_r,       ack_nxt;
  logic [DATA_W-1:0] rdat_r,      rdat_nxt;
  logic [EV_W-1:0]   ev;
  logic [EV_W-1:0]   clr_mask;
  logic              pd_b;
  logic              reg_pd;
  logic              gps_mode;
  logic              bus_req;
  logic              wr_ctrl;
  logic              wr_clr;
  logic              wr_en;
  logic              bus_wr;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] en_word;
  logic [DATA_W-1:0] clr_word;

  // Merge byte lanes of a write into an old value
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [3:0]        sel);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  assign reg_pd   = ctrl_r[CTL_REG_PD];
  assign gps_mode = ctrl_r[CTL_GPS_MODE];
  assign pd_b     = pd_b_s;
  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
  // Writes land at the edge where the master sees ack high
  assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign wr_ctrl  = bus_wr && (wb_adr_i == OFS_CTRL);
  assign wr_clr   = bus_wr && (wb_adr_i == OFS_IRQ_CLR);
  assign wr_en    = bus_wr && (wb_adr_i == OFS_IRQ_EN);
  // Byte-merged write words
  assign ctrl_word = merge_bytes(DATA_W'(ctrl_r), wb_dat_i, wb_sel_i);
  assign en_word   = merge_bytes(DATA_W'(irq_en_r), wb_dat_i, wb_sel_i);
  assign clr_word  = merge_bytes('0, wb_dat_i, wb_sel_i);
  assign clr_mask = wr_clr ? clr_word[EV_W-1:0] : '0;

  always_comb begin
    ctrl_nxt      = ctrl_r;
    irq_en_nxt    = irq_en_r;
    los_nxt       = los_r;
    partner_q_nxt = partner_ok_s;
    pd_q_nxt      = pd_b;
    ack_nxt       = bus_req;
    rdat_nxt      = rdat_r;
    // Hysteresis: hold the last value between the two thresholds
    if (pd_b || reg_pd || !ctrl_r[CTL_LOS_EN]) begin
      los_nxt = 1'b0;
    end else if (rx_below_low_thresh_b) begin
      los_nxt = 1'b1;
    end else if (rx_above_high_thresh_b) begin
      los_nxt = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_nxt = ctrl_word[CTL_W-1:0];
    end
    if (wr_en) begin
      irq_en_nxt = en_word[EV_W-1:0];
    end
    // Read data loads at the taking edge and stands while ack is high
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL:            rdat_nxt = DATA_W'(ctrl_r);
        OFS_STATUS:          rdat_nxt = DATA_W'({pd_b, tx_lanes_aligned_out_b, partner_ok_s, los_r});
        OFS_IRQ_STAT:        rdat_nxt = DATA_W'(irq_stat_r);
        OFS_IRQ_EN:          rdat_nxt = DATA_W'(irq_en_r);
        default:             rdat_nxt = '0;
      endcase
    end
  end

  // Events; a set in the same cycle as a clear wins
  always_comb begin
    ev                 = '0;
    ev[EV_LOS_SET]     = los_nxt && !los_r;
    ev[EV_LOS_CLR]     = !los_nxt && los_r;
    ev[EV_PARTNER_CHG] = gps_mode && (partner_ok_s != partner_q_r);
    ev[EV_PD_EXIT]     = pd_q_r && !pd_b;
    irq_stat_nxt       = (irq_stat_r & ~clr_mask) | ev;
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r      <= CTL_RESET;
      irq_stat_r  <= '0;
      irq_en_r    <= '0;
      los_r       <= 1'b0;
      partner_q_r <= 1'b0;
      pd_q_r      <= 1'b0;
      ack_r       <= 1'b0;
      rdat_r      <= '0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      irq_stat_r  <= irq_stat_nxt;
      irq_en_r    <= irq_en_nxt;
      los_r       <= los_nxt;
      partner_q_r <= partner_q_nxt;
      pd_q_r      <= pd_q_nxt;
      ack_r       <= ack_nxt;
      rdat_r      <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign irq      = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Pins
  logic obs_val;
  logic in_reset;

  assign in_reset = !rst_n_r;

  always_comb begin
    case (ctrl_r[CTL_OBS_SEL_LO +: CTL_OBS_SEL_W])
      OBS_LOS:        obs_val = los_r;
      OBS_PARTNER_OK: obs_val = partner_ok_s;
      OBS_TX_OK:      obs_val = tx_lanes_aligned_out_b;
      OBS_PD:         obs_val = pd_b;
      default:        obs_val = los_r;
    endcase
  end

  assign rx_signal_loss_flag_b    = in_reset ? 1'b0 : obs_val;
  assign rx_signal_loss_flag_b_oe = in_reset || !(pd_b || reg_pd);
  assign tx_lanes_aligned_out_b   = gps_mode && !in_reset && tx_lanes_aligned_b;
  assign channel_b_powered_down   = pd_b || reg_pd;

  assign ref_clk_sel_a     = ctrl_r[CTL_REFSEL_A];
  assign ref_clk_sel_b     = ctrl_r[CTL_REFSEL_B];
  assign channel_a_ref_clk = ref_clk_sel_a ? reference_clock_one : reference_clock_zero;
  assign channel_b_ref_clk = ref_clk_sel_b ? reference_clock_one : reference_clock_zero;

  logic clk_float;
  // Pin power down floats the clocks only when both channels are down
  assign clk_float = in_reset || (pd_b && pd_a_s) || reg_pd;

  assign channel_a_output_clock    = ctrl_r[CTL_CLKSRC_A] ? vco_half_clk_a : byte_clk_a;
  assign channel_b_output_clock    = ctrl_r[CTL_CLKSRC_B] ? vco_half_clk_b : byte_clk_b;
  assign channel_a_output_clock_oe = ctrl_r[CTL_CLKEN_A] && !clk_float;
  assign channel_b_output_clock_oe = ctrl_r[CTL_CLKEN_B] && !clk_float;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_LOS_RESET_LOW: assert property (@(posedge ref_clk)
    in_reset |-> (rx_signal_loss_flag_b_oe && !rx_signal_loss_flag_b)) else $error("loss pin not low in reset");
  AST_LOS_FLOAT_PD: assert property (@(posedge ref_clk) disable iff (in_reset)
    (pd_b || reg_pd) |-> !rx_signal_loss_flag_b_oe) else $error("loss pin driven in power down");
  AST_LOS_SET: assert property (@(posedge ref_clk) disable iff (in_reset)
    (rx_below_low_thresh_b && ctrl_r[CTL_LOS_EN] && !pd_b && !reg_pd) |=> los_r) else $error("loss not set");
  AST_LOS_CLR: assert property (@(posedge ref_clk) disable iff (in_reset)
    (rx_above_high_thresh_b && !rx_below_low_thresh_b) |=> !los_r) else $error("loss not cleared");
  AST_LOS_HOLD: assert property (@(posedge ref_clk) disable iff (in_reset)
    (!rx_below_low_thresh_b && !rx_above_high_thresh_b && ctrl_r[CTL_LOS_EN] && !pd_b && !reg_pd)
    |=> $stable(los_r)) else $error("loss changed between thresholds");
  AST_PD_FOLLOW: assert property (@(posedge ref_clk) disable iff (in_reset)
    !channel_b_power_down_n [*3] |-> channel_b_powered_down) else $error("power down not taken");
  AST_TX_OK: assert property (@(posedge ref_clk) disable iff (in_reset)
    gps_mode |-> (tx_lanes_aligned_out_b == tx_lanes_aligned_b)) else $error("alignment output wrong");
  AST_CLK_FLOAT: assert property (@(posedge ref_clk)
    (in_reset || reg_pd) |-> (!channel_a_output_clock_oe && !channel_b_output_clock_oe))
    else $error("output clock driven while floating");
  AST_PARTNER_EV: assert property (@(posedge ref_clk) disable iff (in_reset)
    (gps_mode && partner_ok_s != partner_q_r) |=> irq_stat_r[EV_PARTNER_CHG]) else $error("partner event lost");
  AST_ACK_PULSE: assert property (@(posedge ref_clk) disable iff (in_reset)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  AST_ACK_ANSWER: assert property (@(posedge ref_clk) disable iff (in_reset)
    bus_req |=> wb_ack_o) else $error("request not answered");
  AST_PD_EXIT_EV: assert property (@(posedge ref_clk) disable iff (in_reset)
    (pd_q_r && !pd_b) |=> irq_stat_r[EV_PD_EXIT]) else $error("power-down exit event lost");
  AST_CLK_PIN_PD: assert property (@(posedge ref_clk) disable iff (in_reset)
    (pd_b && pd_a_s) |-> (!channel_a_output_clock_oe && !channel_b_output_clock_oe)) else $error("clock not floating");
  AST_TX_LOW_OFF: assert property (@(posedge ref_clk) disable iff (in_reset)
    !gps_mode |-> !tx_lanes_aligned_out_b) else $error("alignment output outside mode");
  AST_IRQ_STICKY: assert property (@(posedge ref_clk) disable iff (in_reset)
    (irq_stat_r[EV_LOS_SET] && !clr_mask[EV_LOS_SET]) |=> irq_stat_r[EV_LOS_SET]) else $error("status not sticky");

  COV_LOS_RISE:  cover property (@(posedge ref_clk) disable iff (in_reset) $rose(los_r));
  COV_PD_EXIT:   cover property (@(posedge ref_clk) disable iff (in_reset) ev[EV_PD_EXIT]);
  COV_IRQ:       cover property (@(posedge ref_clk) disable iff (in_reset) $rose(irq));
  COV_VCO_CLK:   cover property (@(posedge ref_clk) disable iff (in_reset)
    ctrl_r[CTL_CLKSRC_B] && channel_b_output_clock_oe);
  COV_PARTNER:   cover property (@(posedge ref_clk) disable iff (in_reset) ev[EV_PARTNER_CHG]);

endmodule : csco_top

// file: tb/csco_partner_model.sv
// Behavioural link partner: lane-alignment slave and master for channel B
`timescale 1ns/1ps
module csco_partner_model
  import csco_pkg::*;
(
  input  wire logic clk,              // Partner clock
  input  wire logic rst_n,            // Partner reset, active low
  input  wire logic want_aligned,     // Commanded receive alignment
  input  wire logic slow,             // Long alignment latency
  input  wire logic tx_aligned_in,    // Transmit alignment from device
  output logic      lanes_aligned,    // Receive alignment to device
  output logic      tx_aligned_seen   // Transmit alignment as latched
);
  logic [3:0] wait_r;
  logic [3:0] wait_nxt;
  logic       aligned_r;
  logic       aligned_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Alignment follows the command after a prompt or slow delay
  always_comb begin
    wait_nxt    = wait_r;
    aligned_nxt = aligned_r;
    if (want_aligned == aligned_r) begin
      wait_nxt = slow ? 4'h6 : 4'h1;
    end else if (wait_r > 4'h1) begin
      wait_nxt = wait_r - 4'h1;
    end else begin
      aligned_nxt = want_aligned;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r          <= 4'h1;
      aligned_r       <= 1'b0;
      tx_aligned_seen <= 1'b0;
    end else begin
      wait_r          <= wait_nxt;
      aligned_r       <= aligned_nxt;
      tx_aligned_seen <= tx_aligned_in;
    end
  end

  assign lanes_aligned = aligned_r;
endmodule : csco_partner_model

// file: tb/csco_top_tb.sv
// Self-checking bench for the channel B status and clock-out block
`timescale 1ns/1ps
module csco_top_tb
  import csco_pkg::*;
;
  // Inputs below, above, partner, tx aligned, then expected pin
  typedef struct packed {
    logic [CTL_W-1:0] ctrl;
    logic [4:0]       ins_exp;
  } csco_row_t;

  csco_row_t rows [9] = '{'{11'h611, 5'b01000}, '{11'h611, 5'b10001}, '{11'h611, 5'b00001},
    '{11'h613, 5'b00101}, '{11'h615, 5'b00100}, '{11'h615, 5'b00111}, '{11'h617, 5'b00110},
    '{11'h611, 5'b01110}, '{11'h610, 5'b10110}};

  logic ref_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [3:0]        wb_sel_i = 4'hF;
  logic [DATA_W-1:0] wb_dat_i = '0, wb_dat_o, v;
  logic wb_ack_o, irq, rx_below_low_thresh_b = 1'b0, rx_above_high_thresh_b = 1'b1;
  logic partner_rx_lanes_aligned_in_b, tx_lanes_aligned_b = 1'b0, channel_b_power_down_n = 1'b1;
  logic channel_a_power_down_n = 1'b1, reference_clock_zero = 1'b0, reference_clock_one = 1'b1;
  logic byte_clk_a = 1'b0, byte_clk_b = 1'b1, vco_half_clk_a = 1'b1, vco_half_clk_b = 1'b0;
  logic ref_clk_sel_a, ref_clk_sel_b, channel_a_ref_clk, channel_b_ref_clk, channel_a_output_clock;
  logic channel_a_output_clock_oe, channel_b_output_clock, channel_b_output_clock_oe, rx_signal_loss_flag_b;
  logic rx_signal_loss_flag_b_oe, tx_lanes_aligned_out_b, channel_b_powered_down;
  logic want = 1'b0, slow = 1'b0, p_tx_seen;
  logic [3:0] pins;
  int   errors = 0, checks_done = 0;

  assign pins = {rx_signal_loss_flag_b_oe, rx_signal_loss_flag_b, channel_a_output_clock_oe, channel_b_output_clock_oe};

  csco_top dut_u (.ref_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .rx_below_low_thresh_b, .rx_above_high_thresh_b, .partner_rx_lanes_aligned_in_b, .tx_lanes_aligned_b,
    .channel_b_power_down_n, .channel_a_power_down_n, .reference_clock_zero, .reference_clock_one, .byte_clk_a,
    .byte_clk_b, .vco_half_clk_a, .vco_half_clk_b, .ref_clk_sel_a, .ref_clk_sel_b, .channel_a_ref_clk,
    .channel_b_ref_clk, .channel_a_output_clock, .channel_a_output_clock_oe, .channel_b_output_clock,
    .channel_b_output_clock_oe, .rx_signal_loss_flag_b, .rx_signal_loss_flag_b_oe, .tx_lanes_aligned_out_b,
    .channel_b_powered_down, .irq);

  csco_partner_model partner_u (.clk(ref_clk), .rst_n(arst_n), .want_aligned(want), .slow(slow),
    .tx_aligned_in(tx_lanes_aligned_out_b), .lanes_aligned(partner_rx_lanes_aligned_in_b),
    .tx_aligned_seen(p_tx_seen));

  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [ADDR_W-1:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    v = wb_dat_o;
    if (wb_ack_o !== 1'b1) errors++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat, 4'hF);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] adr);
    bus(1'b0, adr, 32'h0, 4'hF);
  endtask : rd

  initial begin
    cyc(20000);
    errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    chk(pins, 4'h8);
    cyc(3);
    arst_n <= 1'b1;
    cyc(2);
    rd(OFS_CTRL);
    chk(v, 32'h601);
    chk({pins, channel_a_output_clock, channel_b_output_clock}, 6'b101101);
    foreach (rows[i]) begin
      wr(OFS_CTRL, {21'h0, rows[i].ctrl});
      {rx_below_low_thresh_b, rx_above_high_thresh_b, want, tx_lanes_aligned_b} <= rows[i].ins_exp[4:1];
      cyc(6);
      chk(rx_signal_loss_flag_b, rows[i].ins_exp[0]);
      chk(tx_lanes_aligned_out_b, rows[i].ins_exp[1]);
    end
    wr(OFS_CTRL, 32'h601);
    cyc(3);
    chk({tx_lanes_aligned_out_b, p_tx_seen}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 32'h611 | {23'h0, i[1], i[0], i[1], i[0], 5'h0});
      cyc(2);
      chk({ref_clk_sel_a, ref_clk_sel_b, channel_a_ref_clk, channel_b_ref_clk}, {i[0], i[1], i[0], i[1]});
      chk({channel_a_output_clock, channel_b_output_clock}, {i[0], !i[1]});
    end
    wr(OFS_CTRL, 32'h211);
    cyc(2);
    chk(pins[1:0], 2'b10);
    wr(OFS_CTRL, 32'h611);
    channel_b_power_down_n <= 1'b0;
    cyc(4);
    chk({channel_b_powered_down, rx_signal_loss_flag_b_oe}, 2'b10);
    rd(OFS_STATUS);
    chk(v[ST_PD_B], 1'b1);
    channel_a_power_down_n <= 1'b0;
    cyc(4);
    chk(pins[1:0], 2'b00);
    {channel_a_power_down_n, channel_b_power_down_n} <= 2'b11;
    cyc(4);
    chk({channel_b_powered_down, pins}, 5'b01111);
    rd(OFS_IRQ_STAT);
    chk(v[EV_PD_EXIT], 1'b1);
    wr(OFS_IRQ_CLR, 32'hF);  // Host clears before register power down
    wr(OFS_CTRL, 32'h619);
    cyc(2);
    chk({channel_b_powered_down, pins}, 5'b10000);
    {rx_below_low_thresh_b, rx_above_high_thresh_b, slow} <= 3'b011;
    wr(OFS_CTRL, 32'h615);
    wr(OFS_IRQ_EN, 32'h5);
    rd(OFS_IRQ_EN);
    chk(v, 32'h5);
    wr(OFS_IRQ_CLR, 32'hF);
    cyc(2);
    rd(OFS_IRQ_STAT);
    chk({irq, v[3:0]}, 5'h00);
    {rx_below_low_thresh_b, rx_above_high_thresh_b} <= 2'b10;
    cyc(4);
    rd(OFS_IRQ_STAT);
    chk({irq, v[3:0]}, 5'h11);
    wr(OFS_IRQ_CLR, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    // Partner event while masked, slow partner
    wr(OFS_IRQ_EN, 32'h1);
    want <= 1'b0;
    cyc(1);
    rd(OFS_STATUS);
    chk(v[3:0], 4'h7);
    cyc(10);
    rd(OFS_STATUS);
    chk(v[ST_PARTNER_OK], 1'b0);
    rd(OFS_IRQ_STAT);
    chk({irq, v[3:0]}, 5'h04);
    wr(OFS_IRQ_EN, 32'h5);
    cyc(2);
    chk(irq, 1'b1);
    wr(OFS_IRQ_CLR, 32'h4);
    cyc(2);
    chk(irq, 1'b0);
    // Read-only, unmapped and byte-select accesses
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS);
    chk(v, 32'h5);
    rd(5'h02);
    chk(v, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0, 4'h1);
    rd(OFS_CTRL);
    chk(v, 32'h600);
    arst_n <= 1'b0;
    cyc(2);
    chk({irq, pins}, 5'h08);
    arst_n <= 1'b1;
    cyc(2);
    rd(OFS_CTRL);
    chk(v, 32'h601);
    rd(OFS_IRQ_EN);
    chk(v, 32'h0);
    report_and_stop();
  end
endmodule : csco_top_tb
